// [control_word_scheduler.sv]
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ns
module control_word_scheduler (
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic             clkEn,
	input  wire logic             bitClkPin,
	input  wire logic [3:0]       srcPins,
	input  wire cws_pkg::busReq_s busReq,
	output logic [31:0]           rdData,
	output cws_pkg::txOut_s       txOut,
	output logic [3:0]            wordEnable,
	output logic                  dispStrobe
);

	function automatic logic isUsedWord(input logic [3:0] code);
		isUsedWord = (code == cws_pkg::WORD0) || (code == cws_pkg::WORD1)
			|| (code == cws_pkg::WORD3);
	endfunction

	// pin synchronisers and link clock edge
	logic [4:0] syncA_reg;
	logic [4:0] syncA_next;
	logic [4:0] syncB_reg;
	logic [4:0] syncB_next;
	logic       bitClkD_reg;
	logic       bitClkD_next;
	logic       tick;

	always_comb begin
		syncA_next   = syncA_reg;
		syncB_next   = syncB_reg;
		bitClkD_next = bitClkD_reg;
		if (clkEn) begin
			syncA_next   = {bitClkPin, srcPins};
			syncB_next   = syncA_reg;
			bitClkD_next = syncB_reg[4];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			syncA_reg   <= 5'h00;
			syncB_reg   <= 5'h00;
			bitClkD_reg <= 1'b0;
		end else begin
			syncA_reg   <= syncA_next;
			syncB_reg   <= syncB_next;
			bitClkD_reg <= bitClkD_next;
		end
	end

	assign tick = clkEn && syncB_reg[4] && !bitClkD_reg;

	// register port
	logic [1:0]  src_reg;
	logic [1:0]  src_next;
	logic [31:0] freqSet_reg;
	logic [31:0] freqSet_next;
	logic [31:0] modeSet_reg;
	logic [31:0] modeSet_next;
	logic        freqChgN_reg;
	logic        freqChgN_next;
	logic [31:0] rdData_reg;
	logic [31:0] rdData_next;
	logic        wrEff;
	logic        localOn;
	logic        freqRstCmd;
	logic        freqChange;
	logic        modeChange;

	logic [6:0]  phase_reg;
	logic [3:0]  wp_reg;
	logic [3:0]  newCnt_reg;
	logic [3:0]  sendWord_reg;
	logic        inserted_reg;
	logic        freqLatch_reg;
	logic        modeLatch_reg;
	logic        modeDone_reg;
	logic [31:0] freqDisp_reg;
	logic [31:0] modeDisp_reg;

	assign wrEff   = clkEn && busReq.wr;
	// local controls dead in readback mode
	assign localOn = (src_reg != cws_pkg::SRC_READBACK);
	assign freqRstCmd = wrEff && localOn
		&& (busReq.addr == cws_pkg::CMD_OFS)
		&& busReq.wdata[cws_pkg::CMD_FRST_BIT];
	assign freqChange = wrEff && localOn
		&& (busReq.addr == cws_pkg::FREQ_OFS)
		&& (busReq.wdata != freqSet_reg);
	assign modeChange = wrEff && localOn
		&& (busReq.addr == cws_pkg::MODE_OFS)
		&& (|(busReq.wdata ^ modeSet_reg));

	always_comb begin
		src_next      = src_reg;
		freqSet_next  = freqSet_reg;
		modeSet_next  = modeSet_reg;
		freqChgN_next = freqChgN_reg;
		rdData_next   = 32'h0000_0000;
		if (wrEff && busReq.addr == cws_pkg::CTRL_OFS)
			src_next = busReq.wdata[1:0];
		if (freqChange) begin
			freqSet_next  = busReq.wdata;
			freqChgN_next = 1'b0;
		end
		if (modeChange)
			modeSet_next = busReq.wdata;
		if (freqRstCmd)
			freqChgN_next = 1'b1;
		if (clkEn && busReq.rd) begin
			case (busReq.addr)
				cws_pkg::CTRL_OFS:  rdData_next = {30'h0, src_reg};
				cws_pkg::FREQ_OFS:  rdData_next = freqSet_reg;
				cws_pkg::MODE_OFS:  rdData_next = modeSet_reg;
				cws_pkg::STAT_OFS:  rdData_next = {8'h00, modeDone_reg,
					inserted_reg, freqChgN_reg, modeLatch_reg,
					freqLatch_reg, phase_reg, sendWord_reg,
					newCnt_reg, wp_reg};
				cws_pkg::FDISP_OFS: rdData_next = freqDisp_reg;
				cws_pkg::MDISP_OFS: rdData_next = modeDisp_reg;
				default:            rdData_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			src_reg      <= cws_pkg::CTRL_RST;
			freqSet_reg  <= cws_pkg::SET_RST;
			modeSet_reg  <= cws_pkg::SET_RST;
			freqChgN_reg <= 1'b1;
			rdData_reg   <= 32'h0000_0000;
		end else begin
			src_reg      <= src_next;
			freqSet_reg  <= freqSet_next;
			modeSet_reg  <= modeSet_next;
			freqChgN_reg <= freqChgN_next;
			rdData_reg   <= rdData_next;
		end
	end

	assign rdData = rdData_reg;

	// word scheduler
	logic [6:0]  phase_next;
	logic [3:0]  wp_next;
	logic [3:0]  newCnt_next;
	logic [3:0]  sendWord_next;
	logic        inserted_next;
	logic        freqLatch_next;
	logic        modeLatch_next;
	logic        modeDone_next;
	logic [31:0] freqSh_reg;
	logic [31:0] freqSh_next;
	logic [31:0] modeSh_reg;
	logic [31:0] modeSh_next;
	cws_pkg::txOut_s tx_reg;
	cws_pkg::txOut_s tx_next;
	logic        strobe;
	logic        shiftT;
	logic        cntT;
	logic        word1_qualify_gate;
	logic        wpHalt;
	logic        new_counter_halt_gate;
	logic [3:0]  selWord;
	logic [3:0]  curWord;
	logic        curIns;
	logic        freq_output_gate;
	logic        mode_output_gate;
	logic        mode_latch_set_or;
	logic        mode_latch_clear_gate;
	logic [31:0] srcF;
	logic [31:0] srcM;

	// pair of 96 bit times: 32 data, 16 count, 32 repeat, 16 count
	assign strobe = tick && (phase_reg == 7'h00);
	assign shiftT = tick && (phase_reg < cws_pkg::WORD_BITS);
	assign cntT   = tick && ((phase_reg >= cws_pkg::WORD_BITS
		&& phase_reg < cws_pkg::FRAME_BITS)
		|| phase_reg >= cws_pkg::REPEAT_END);

	// pending frequency change hides word 1
	assign word1_qualify_gate = (wp_reg == cws_pkg::WORD1)
		&& freqChgN_reg;
	// unused codes never halt; a routine word just sent is left behind
	assign wpHalt = isUsedWord(wp_reg)
		&& (wp_reg != cws_pkg::WORD1 || word1_qualify_gate)
		&& (wp_reg != sendWord_reg || inserted_reg);
	assign new_counter_halt_gate =
		(newCnt_reg == cws_pkg::WORD3 && modeLatch_reg && !modeDone_reg)
		|| (newCnt_reg == cws_pkg::WORD1 && freqLatch_reg);
	// wp stays put while new words go in, so routine resumes
	assign selWord = new_counter_halt_gate ? newCnt_reg
		: wp_reg;
	assign curWord = strobe ? selWord : sendWord_reg;
	assign curIns  = strobe ? new_counter_halt_gate : inserted_reg;
	assign freq_output_gate = (curWord == cws_pkg::WORD1)
		&& freqChgN_reg;
	assign mode_output_gate = (curWord == cws_pkg::WORD3);
	assign srcF = strobe ? freqSet_reg : freqSh_reg;
	assign srcM = strobe ? modeSet_reg : modeSh_reg;
	assign mode_latch_set_or = modeChange || freqChange;
	assign mode_latch_clear_gate = strobe && modeDone_reg
		&& (selWord != cws_pkg::WORD3);

	always_comb begin
		phase_next     = phase_reg;
		wp_next        = wp_reg;
		newCnt_next    = newCnt_reg;
		sendWord_next  = sendWord_reg;
		inserted_next  = inserted_reg;
		freqLatch_next = freqLatch_reg;
		modeLatch_next = modeLatch_reg;
		modeDone_next  = modeDone_reg;
		freqSh_next    = freqSh_reg;
		modeSh_next    = modeSh_reg;
		tx_next        = tx_reg;
		tx_next.valid  = 1'b0;
		tx_next.strobe = 1'b0;
		if (tick)
			phase_next = (phase_reg == cws_pkg::PAIR_LAST) ? 7'h00
				: phase_reg + 7'h01;
		if (cntT) begin
			if (!wpHalt)
				wp_next = wp_reg + 4'h1;
			if (!new_counter_halt_gate)
				newCnt_next = newCnt_reg + 4'h1;
		end
		if (strobe) begin
			newCnt_next   = selWord;
			sendWord_next = selWord;
			inserted_next = new_counter_halt_gate;
			if (new_counter_halt_gate && selWord == cws_pkg::WORD3)
				modeDone_next = 1'b1;
		end
		if (shiftT) begin
			freqSh_next = {srcF[30:0], 1'b0};
			modeSh_next = {srcM[30:0], 1'b0};
			// word 0 stays all zero; inserted words go out inverted
			tx_next.data = ((freq_output_gate && srcF[31])
				|| (mode_output_gate && srcM[31]))
				^ (curIns && (freq_output_gate
				|| mode_output_gate));
			tx_next.valid    = 1'b1;
			tx_next.strobe   = strobe;
			tx_next.inserted = curIns;
			tx_next.word     = curWord;
		end
		if (strobe)
			freqLatch_next = 1'b0;
		if (freqRstCmd)
			freqLatch_next = 1'b1;
		if (mode_latch_clear_gate)
			modeLatch_next = 1'b0;
		if (mode_latch_clear_gate || mode_latch_set_or)
			modeDone_next  = 1'b0;
		if (mode_latch_set_or)
			modeLatch_next = 1'b1; // set beats clear
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			phase_reg     <= 7'h00;
			wp_reg        <= 4'h0;
			newCnt_reg    <= 4'h0;
			sendWord_reg  <= cws_pkg::WORD3;
			inserted_reg  <= 1'b0;
			freqLatch_reg <= 1'b0;
			modeLatch_reg <= 1'b0;
			modeDone_reg  <= 1'b0;
			freqSh_reg    <= 32'h0000_0000;
			modeSh_reg    <= 32'h0000_0000;
			tx_reg        <= '0;
		end else begin
			phase_reg     <= phase_next;
			wp_reg        <= wp_next;
			newCnt_reg    <= newCnt_next;
			sendWord_reg  <= sendWord_next;
			inserted_reg  <= inserted_next;
			freqLatch_reg <= freqLatch_next;
			modeLatch_reg <= modeLatch_next;
			modeDone_reg  <= modeDone_next;
			freqSh_reg    <= freqSh_next;
			modeSh_reg    <= modeSh_next;
			tx_reg        <= tx_next;
		end
	end

	assign txOut      = tx_reg;
	assign wordEnable = newCnt_reg;

	// receive side; no sync search, frames counted from reset
	logic [47:0] rxSh_reg;
	logic [47:0] rxSh_next;
	logic [5:0]  rxCnt_reg;
	logic [5:0]  rxCnt_next;
	logic [31:0] freqDisp_next;
	logic [31:0] modeDisp_next;
	logic        dispStrobe_reg;
	logic        dispStrobe_next;
	logic [3:0]  rxCode;
	logic        rxEnd;

	assign rxSh_next = {rxSh_reg[46:0], syncB_reg[src_reg]};
	assign rxEnd     = tick && (rxCnt_reg == cws_pkg::RX_LAST);
	// first bit lands in bit 47, so frame bit n sits at 47-n
	assign rxCode = {rxSh_next[47 - cws_pkg::CODE_LO - 3],
		rxSh_next[47 - cws_pkg::CODE_LO - 2],
		rxSh_next[47 - cws_pkg::CODE_LO - 1],
		rxSh_next[47 - cws_pkg::CODE_LO]};

	always_comb begin
		rxCnt_next      = rxCnt_reg;
		freqDisp_next   = freqDisp_reg;
		modeDisp_next   = modeDisp_reg;
		dispStrobe_next = 1'b0;
		if (tick)
			rxCnt_next = rxEnd ? 6'h00 : rxCnt_reg + 6'h01;
		if (rxEnd) begin
			dispStrobe_next = 1'b1;
			if (rxCode == cws_pkg::WORD1)
				freqDisp_next = rxSh_next[31:0];
			if (rxCode == cws_pkg::WORD3)
				modeDisp_next = rxSh_next[31:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rxSh_reg       <= 48'h0000_0000_0000;
			rxCnt_reg      <= 6'h00;
			freqDisp_reg   <= 32'h0000_0000;
			modeDisp_reg   <= 32'h0000_0000;
			dispStrobe_reg <= 1'b0;
		end else begin
			if (tick)
				rxSh_reg <= rxSh_next;
			rxCnt_reg      <= rxCnt_next;
			freqDisp_reg   <= freqDisp_next;
			modeDisp_reg   <= modeDisp_next;
			dispStrobe_reg <= dispStrobe_next;
		end
	end

	assign dispStrobe = dispStrobe_reg;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	a_wp_wraps: assert property (
		(cntT && wp_reg == 4'hF) |=> (wp_reg == 4'h0))
		else $error("word-present counter did not wrap");
	a_preset_word: assert property (
		(strobe && !new_counter_halt_gate)
		|=> (wordEnable == $past(wp_reg)))
		else $error("word enables not preset from word-present");
	a_load_freq: assert property (
		strobe |=> (freqSh_reg == ($past(freqSet_reg) << 1)))
		else $error("frequency shift register not loaded");
	a_freq_clear: assert property (
		(strobe && !freqRstCmd) |=> !freqLatch_reg)
		else $error("frequency latch not cleared by strobe");
	a_word1_stop: assert property (
		(cntT && word1_qualify_gate && sendWord_reg != cws_pkg::WORD1)
		|=> $stable(wp_reg))
		else $error("word-present ran past word 1");
	a_data_gated: assert property (
		(tick && phase_reg > 7'h00 && phase_reg < cws_pkg::WORD_BITS)
		|=> ($stable(wp_reg) && $stable(newCnt_reg)))
		else $error("counters moved during data bits");
	a_unused_skip: assert property (
		(cntT && !isUsedWord(wp_reg))
		|=> (wp_reg == $past(wp_reg) + 4'h1))
		else $error("word-present halted on unused code");
	a_mode_set: assert property (
		mode_latch_set_or |=> modeLatch_reg)
		else $error("mode latch not set by change");
	a_nd_halt: assert property (
		(cntT && modeLatch_reg && !modeDone_reg
		&& newCnt_reg == cws_pkg::WORD3)
		|=> (newCnt_reg == cws_pkg::WORD3))
		else $error("new-data counter did not halt at 3");
	a_freq_block: assert property (
		freqChange |=> (!freqChgN_reg ##1 !freqChgN_reg
		or freqRstCmd))
		else $error("frequency change detector not low");
	a_disp_strobe: assert property (
		rxEnd |=> (dispStrobe ##1 !dispStrobe))
		else $error("display strobe missing or too long");

	c_mode_insert: cover property (
		strobe && new_counter_halt_gate
		&& selWord == cws_pkg::WORD3);
	c_freq_insert: cover property (
		strobe && new_counter_halt_gate
		&& selWord == cws_pkg::WORD1);
	c_word1_load: cover property (
		rxEnd && rxCode == cws_pkg::WORD1);

endmodule // control_word_scheduler

// [cws_pkg.sv]
package cws_pkg;
	localparam logic [7:0]  CTRL_OFS      = 8'h00;
	localparam logic [7:0]  CMD_OFS       = 8'h04;
	localparam logic [7:0]  FREQ_OFS      = 8'h08;
	localparam logic [7:0]  MODE_OFS      = 8'h0C;
	localparam logic [7:0]  STAT_OFS      = 8'h10;
	localparam logic [7:0]  FDISP_OFS     = 8'h14;
	localparam logic [7:0]  MDISP_OFS     = 8'h18;
	localparam int          CMD_FRST_BIT  = 0;
	localparam logic [1:0]  SRC_READBACK  = 2'h0;
	localparam logic [1:0]  SRC_RECALL    = 2'h1;
	localparam logic [1:0]  SRC_HIGHWAY   = 2'h2;
	localparam logic [1:0]  SRC_EXTERNAL  = 2'h3;
	localparam logic [1:0]  CTRL_RST      = 2'h3;
	localparam logic [31:0] SET_RST       = 32'h0000_0000;
	localparam logic [3:0]  WORD0         = 4'h0;
	localparam logic [3:0]  WORD1         = 4'h1;
	localparam logic [3:0]  WORD3         = 4'h3;
	localparam logic [6:0]  WORD_BITS     = 7'h20;
	localparam logic [6:0]  FRAME_BITS    = 7'h30;
	localparam logic [6:0]  REPEAT_END    = 7'h50;
	localparam logic [6:0]  PAIR_LAST     = 7'h5F;
	localparam logic [5:0]  RX_LAST       = 6'h2F;
	localparam int          CODE_LO       = 12;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} busReq_s;
	typedef struct packed {
		logic       data;
		logic       valid;
		logic       strobe;
		logic       inserted;
		logic [3:0] word;
	} txOut_s;
endpackage

// [cws_remote_model.sv]
`timescale 1ns/1ns
module cws_remote_model (
	input  wire logic        rstn,
	input  wire logic [3:0]  frameCode,
	input  wire logic [31:0] frameData,
	output logic             bitClk,
	output logic             lineOut,
	output logic             take
);
	logic [47:0] frame;
	int          n;

	// master bit clock runs free; data moves on the falling edge
	initial begin
		bitClk = 1'b0;
		lineOut = 1'b1;
		take = 1'b0;
		n = 0;
		frame = '0;
		wait (rstn === 1'b1);
		// offset keeps link edges away from system clock edges
		#130;
		forever begin
			if (n == 0) begin
				frame = '0; // preamble filler
				for (int i = 0; i < 4; i++)
					frame[12 + i] = frameCode[i];
				for (int i = 0; i < 32; i++)
					frame[16 + i] = frameData[31 - i];
				take = ~take;
			end
			lineOut = frame[n];
			#400 bitClk = 1'b1;
			#400 bitClk = 1'b0;
			n = (n + 1) % 48;
		end
	end
endmodule // cws_remote_model

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
	logic             clk_sys;
	logic             rstn;
	logic             clkEn;
	logic [3:0]       noise;
	logic [3:0]       srcPins;
	cws_pkg::busReq_s busReq;
	logic [31:0]      rdData;
	cws_pkg::txOut_s  txOut;
	logic [3:0]       wordEnable;
	logic             dispStrobe;
	logic             bitClk;
	logic             line;
	logic             take;
	logic [3:0]       nextCode;
	logic [31:0]      nextData;
	logic [31:0]      freqM, modeM, freqS, modeS, got, e, expF, expM, q;
	logic [35:0]      frameQ[$];
	logic [3:0]       lastR, wcode;
	logic [1:0]       src;
	logic             ins, freqBlk, freqPend, modePend;
	int               bad_count, check_count, bits, cyc, lastTx, lastDisp;

	// partner line goes to the selected source, noise on the rest
	assign srcPins = line ? noise | (4'h1 << src) : noise & ~(4'h1 << src);

	control_word_scheduler dut (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.clkEn      (clkEn),
		.bitClkPin  (bitClk),
		.srcPins    (srcPins),
		.busReq     (busReq),
		.rdData     (rdData),
		.txOut      (txOut),
		.wordEnable (wordEnable),
		.dispStrobe (dispStrobe)
	);

	cws_remote_model remote (
		.rstn      (rstn),
		.frameCode (nextCode),
		.frameData (nextData),
		.bitClk    (bitClk),
		.lineOut   (line),
		.take      (take)
	);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] x,
		input string m);
		check_count++;
		if (g !== x) begin
			bad_count++;
			$display("wrong value at %0t: %s %h/%h", $time, m, g, x);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// one access, then one idle cycle so no strobe is assigned twice
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		busReq <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk_sys);
		busReq.wr <= 1'b0;
		busReq.rd <= 1'b0;
		if (w && a == cws_pkg::CTRL_OFS)
			src = d[1:0];
		else if (w && src != cws_pkg::SRC_READBACK) begin
			if (a == cws_pkg::FREQ_OFS && d != freqM) begin
				freqM = d;
				freqBlk = 1'b1;
				modePend = 1'b1;
			end
			if (a == cws_pkg::MODE_OFS && d != modeM) begin
				modeM = d;
				modePend = 1'b1;
			end
			if (a == cws_pkg::CMD_OFS && d[0]) begin
				freqBlk = 1'b0;
				freqPend = 1'b1;
			end
		end
		@(negedge clk_sys);
		q = rdData;
		@(posedge clk_sys);
	endtask

	task automatic wait_for(input bit disp, input int n);
		int k;
		k = 0;
		while (n > 0 && k < 4000) begin
			@(posedge clk_sys);
			k++;
			if ((disp ? dispStrobe : txOut.strobe) === 1'b1)
				n--;
		end
		if (n > 0)
			chk(n, 0, "wait limit");
		@(posedge clk_sys);
	endtask

	always @(take) begin
		if (rstn === 1'b1) begin
			frameQ.push_back({nextCode, nextData});
			nextCode <= 4'($urandom_range(4, 0));
			nextData <= $urandom;
		end
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (dispStrobe === 1'b1) begin
			if (lastDisp > 0)
				chk(cyc - lastDisp, 48 * 8, "frame spacing");
			lastDisp = cyc;
			noise <= 4'($urandom);
			if (frameQ.size() > 0) begin
				if (frameQ[0][35:32] == cws_pkg::WORD1)
					expF = frameQ[0][31:0];
				if (frameQ[0][35:32] == cws_pkg::WORD3)
					expM = frameQ[0][31:0];
				void'(frameQ.pop_front());
			end
		end
		if (txOut.strobe === 1'b1) begin
			if (lastTx > 0)
				chk(cyc - lastTx, 96 * 8, "pair spacing");
			if (lastTx > 0)
				chk(bits, 32, "bits per word");
			lastTx = cyc;
			bits = 0;
			wcode = txOut.word;
			ins = txOut.inserted;
			freqS = freqM;
			modeS = modeM;
			if (ins === 1'b1) begin
				chk(wcode == 1 ? freqPend : wcode == 3 && modePend, 1, "cause");
				if (wcode == 1)
					freqPend = 1'b0;
				if (wcode == 3)
					modePend = 1'b0;
			end else begin
				lastR = lastR == 0 ? (freqBlk ? 4'h3 : 4'h1) : lastR == 1 ? 4'h3 : 4'h0;
				chk(wcode, lastR, "word order");
			end
		end
		if (txOut.valid === 1'b1) begin
			got = {got[30:0], txOut.data};
			bits++;
			e = wcode == 1 ? freqS : wcode == 3 ? modeS : 32'h0;
			if (bits == 2)
				chk(wordEnable, wcode, "word enable");
			if (bits == 32)
				chk(got, ins ? ~e : e, "word data");
		end
	end

	initial begin
		rstn = 1'b0;
		clkEn = 1'b1;
		noise = 4'h0;
		busReq = '0;
		nextCode = 4'h1;
		nextData = 32'h0;
		{freqM, modeM, expF, expM, got} = '0;
		{freqBlk, freqPend, modePend, ins} = '0;
		src = cws_pkg::CTRL_RST;
		wcode = 4'h0;
		lastR = cws_pkg::WORD3;
		{bad_count, check_count, bits, cyc, lastTx, lastDisp} = '0;
		void'($urandom(32'h5A9169D4));
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		bus(1'b0, cws_pkg::CTRL_OFS, 32'h0);
		chk(q[1:0], cws_pkg::CTRL_RST, "ctrl reset");
		bus(1'b0, 8'h1C, 32'h0);
		chk(q, 32'h0, "unmapped read");
		wait_for(1'b0, 4);
		$display("routine sequence test done");
		bus(1'b1, cws_pkg::MODE_OFS, modeM ^ ($urandom | 32'h1));
		wait_for(1'b0, 3);
		chk(modePend, 0, "mode word sent");
		$display("mode insertion test done");
		bus(1'b1, cws_pkg::FREQ_OFS, freqM ^ ($urandom | 32'h1));
		wait_for(1'b0, 4);
		chk(modePend, 0, "mode after freq");
		bus(1'b1, cws_pkg::CMD_OFS, 32'h1);
		wait_for(1'b0, 4);
		chk(freqPend, 0, "freq word sent");
		$display("frequency change test done");
		// switch right after a frame ends so no frame is split
		for (int s = 3; s >= 0; s--) begin
			wait_for(1'b1, 1);
			bus(1'b1, cws_pkg::CTRL_OFS, s);
			wait_for(1'b1, 7);
			bus(1'b0, cws_pkg::FDISP_OFS, 32'h0);
			chk(q, expF, "freq display");
			bus(1'b0, cws_pkg::MDISP_OFS, 32'h0);
			chk(q, expM, "mode display");
		end
		$display("display source test done");
		bus(1'b1, cws_pkg::FREQ_OFS, ~freqM);
		bus(1'b1, cws_pkg::MODE_OFS, ~modeM);
		wait_for(1'b0, 4);
		chk(modePend, 0, "readback writes");
		bus(1'b0, cws_pkg::FREQ_OFS, 32'h0);
		chk(q, freqM, "freq kept");
		bus(1'b0, cws_pkg::MODE_OFS, 32'h0);
		chk(q, modeM, "mode kept");
		$display("readback test done");
		give_verdict;
	end

	// the sequence needs about 3 ms
	initial begin
		#8000000;
		bad_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		give_verdict;
	end
endmodule // tb_top
